// file: hw/quadrature_position_velocity.sv
// quadrature encoder decoder with position integrator, velocity unit and wishbone registers
//
// Design decisions made here: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
module quadrature_position_velocity #(
	parameter int PRESCALE_W = 7
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic encoder_channel_a_i,
	input wire logic encoder_channel_b_i,
	input wire logic index_i,
	output logic irq_o
);
	// byte-lane merge for partial writes
	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] upd, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[8*i +: 8] = upd[8*i +: 8];
			end
		end
		return res;
	endfunction

	logic [1:0] a_sync, b_sync, idx_sync;
	logic a_prev, b_prev, idx_prev;
	logic [31:0] encoder_control_reg, position_reg, position_limit_reg, velocity_period_reload_reg;
	logic [31:0] timer_reg, running_edge_tally_reg, period_edge_total_reg;
	logic [3:0] irq_enable_reg, irq_raw_reg, ev_set;
	logic dir_status, err_status;
	logic [PRESCALE_W-1:0] pre_cnt, pre_mask;
	logic wr_now, wr_ctl, wr_pos, wr_limit, wr_reload, wr_en, wr_clr;
	logic ch_a, ch_b, edge_a, edge_b, idx_rise;
	logic en, vel_on, step, up, phase_err, dir_change, index_hit, expire, vel_pulse;
	logic [31:0] tally_sum, read_mux, next_pos, next_ctl;

	// two-stage synchronisers
	// first stage feeds only the second stage to keep metastability contained
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			a_sync <= quad_enc_pkg::RST_SYNC;
			b_sync <= quad_enc_pkg::RST_SYNC;
			idx_sync <= quad_enc_pkg::RST_SYNC;
		end else begin
			a_sync <= {a_sync[0], encoder_channel_a_i};
			b_sync <= {b_sync[0], encoder_channel_b_i};
			idx_sync <= {idx_sync[0], index_i};
		end
	end

	// swap ahead of every decoding stage
	assign ch_a = encoder_control_reg[quad_enc_pkg::CTL_SWAP] ? b_sync[1] : a_sync[1];
	assign ch_b = encoder_control_reg[quad_enc_pkg::CTL_SWAP] ? a_sync[1] : b_sync[1];

	// previous post-swap levels for edge detection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			a_prev <= 1'b0;
			b_prev <= 1'b0;
			idx_prev <= 1'b0;
		end else begin
			a_prev <= ch_a;
			b_prev <= ch_b;
			idx_prev <= idx_sync[1];
		end
	end

	// one edge per clock is seen, so quarter-rate inputs are never missed
	assign edge_a = ch_a ^ a_prev;
	assign edge_b = ch_b ^ b_prev;
	assign idx_rise = idx_sync[1] & ~idx_prev;
	assign en = encoder_control_reg[quad_enc_pkg::CTL_ENABLE];
	// velocity unit runs only under the position enable
	assign vel_on = en & encoder_control_reg[quad_enc_pkg::CTL_VEL];

	// step and direction decode
	always_comb begin
		step = 1'b0;
		up = 1'b1;
		phase_err = 1'b0;
		if (encoder_control_reg[quad_enc_pkg::CTL_SIG]) begin
			// rising A steps, B low means forward
			step = edge_a & ch_a;
			up = ~ch_b;
		end else begin
			// both channels moving at once is a phase error
			phase_err = edge_a & edge_b;
			// A leading means the moved A now differs from B
			up = edge_a ? (ch_a ^ ch_b) : ~(ch_a ^ ch_b);
			// A edges give two counts per line, both give four
			if (encoder_control_reg[quad_enc_pkg::CTL_EDGE]) begin
				step = (edge_a | edge_b) & ~phase_err;
			end else begin
				step = edge_a & ~phase_err;
			end
		end
		step = step & en;
		phase_err = phase_err & en;
	end

	// a step against the direction of the previous step is a direction change
	assign dir_change = step & (up == dir_status);
	// index only clears position in wrap-on-index mode
	assign index_hit = en & idx_rise;

	// register bus decode, write commits on the edge that sees ack
	assign wr_now = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
	assign wr_ctl = wr_now & (wb_adr_i == quad_enc_pkg::OFF_CTL);
	assign wr_pos = wr_now & (wb_adr_i == quad_enc_pkg::OFF_POS);
	assign wr_limit = wr_now & (wb_adr_i == quad_enc_pkg::OFF_LIMIT);
	assign wr_reload = wr_now & (wb_adr_i == quad_enc_pkg::OFF_RELOAD);
	assign wr_en = wr_now & (wb_adr_i == quad_enc_pkg::OFF_IRQ_EN);
	assign wr_clr = wr_now & (wb_adr_i == quad_enc_pkg::OFF_IRQ_CLR);

	// control word, only fields that exist are kept
	always_comb begin
		next_ctl = merge_bytes(encoder_control_reg, wb_dat_i, wb_sel_i) & 32'h0000_01FF;
		// velocity enable is refused without the position enable
		next_ctl[quad_enc_pkg::CTL_VEL] = next_ctl[quad_enc_pkg::CTL_VEL] & next_ctl[quad_enc_pkg::CTL_ENABLE];
	end

	// software-owned configuration registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			encoder_control_reg <= quad_enc_pkg::RST_WORD;
			position_limit_reg <= quad_enc_pkg::RST_WORD;
			velocity_period_reload_reg <= quad_enc_pkg::RST_WORD;
			irq_enable_reg <= quad_enc_pkg::RST_EV;
		end else begin
			if (wr_ctl) begin
				encoder_control_reg <= next_ctl;
			end
			// software writes edges per turn minus one here
			if (wr_limit) begin
				position_limit_reg <= merge_bytes(position_limit_reg, wb_dat_i, wb_sel_i);
			end
			// software writes period minus one here
			if (wr_reload) begin
				velocity_period_reload_reg <= merge_bytes(velocity_period_reload_reg, wb_dat_i, wb_sel_i);
			end
			if (wr_en) begin
				irq_enable_reg <= wb_dat_i[quad_enc_pkg::EV_W-1:0];
			end
		end
	end

	// position arithmetic with wrap at both ends
	always_comb begin
		next_pos = position_reg;
		if (wr_pos) begin
			next_pos = merge_bytes(position_reg, wb_dat_i, wb_sel_i);
		end else if (index_hit && encoder_control_reg[quad_enc_pkg::CTL_WRAP]) begin
			next_pos = quad_enc_pkg::RST_WORD;
		end else if (step && up) begin
			// past the maximum comes back to zero
			next_pos = (position_reg >= position_limit_reg) ? quad_enc_pkg::RST_WORD : position_reg + 32'h0000_0001;
		end else if (step) begin
			next_pos = (position_reg == 32'h0000_0000) ? position_limit_reg : position_reg - 32'h0000_0001;
		end
	end

	// position only counts while enabled, step is gated by enable; bus writes land at any time
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			position_reg <= quad_enc_pkg::RST_WORD;
		end else begin
			position_reg <= next_pos;
		end
	end

	// direction and error status follow the latest decode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dir_status <= 1'b0;
			err_status <= 1'b0;
		end else begin
			if (step) begin
				dir_status <= ~up;
			end
			err_status <= phase_err | (err_status & ~step); // sticks until the next valid count
		end
	end

	// prescaler sees the same step stream as the position
	assign pre_mask = PRESCALE_W'((8'h01 << encoder_control_reg[quad_enc_pkg::CTL_DIV_LO +: quad_enc_pkg::CTL_DIV_W]) - 8'h01);
	assign vel_pulse = vel_on & step & (pre_cnt == pre_mask);

	// prescale divider, holds while the velocity unit is off
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_cnt <= '0;
		end else if (vel_on && step) begin
			pre_cnt <= (pre_cnt == pre_mask) ? '0 : pre_cnt + 1'b1;
		end
	end

	// timer expires at zero and reloads on the next edge
	assign expire = vel_on & (timer_reg == 32'h0000_0000);
	assign tally_sum = running_edge_tally_reg + {31'h0, vel_pulse};

	// velocity timer, tally and period total
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer_reg <= quad_enc_pkg::RST_WORD;
			running_edge_tally_reg <= quad_enc_pkg::RST_WORD;
			period_edge_total_reg <= quad_enc_pkg::RST_WORD;
		end else if (vel_on) begin
			if (expire) begin
				timer_reg <= velocity_period_reload_reg;
				// the edge of the final cycle still counts
				period_edge_total_reg <= tally_sum;
				running_edge_tally_reg <= quad_enc_pkg::RST_WORD;
			end else begin
				timer_reg <= timer_reg - 32'h0000_0001;
				running_edge_tally_reg <= tally_sum;
			end
		end
	end

	always_comb begin
		ev_set[quad_enc_pkg::EV_INDEX] = index_hit;
		ev_set[quad_enc_pkg::EV_TIMER] = expire;
		ev_set[quad_enc_pkg::EV_DIR] = dir_change;
		ev_set[quad_enc_pkg::EV_ERR] = phase_err;
	end

	// sticky raw bits, write one to clear, a new event beats the clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_raw_reg <= quad_enc_pkg::RST_EV;
		end else begin
			irq_raw_reg <= (irq_raw_reg & ~(wr_clr ? wb_dat_i[quad_enc_pkg::EV_W-1:0] : 4'h0)) | ev_set;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_raw_reg & irq_enable_reg);
		end
	end

	// read mux, unmapped offsets read zero
	always_comb begin
		unique case (wb_adr_i)
			quad_enc_pkg::OFF_CTL: read_mux = encoder_control_reg;
			quad_enc_pkg::OFF_STAT: read_mux = {30'h0, dir_status, err_status};
			quad_enc_pkg::OFF_POS: read_mux = position_reg;
			quad_enc_pkg::OFF_LIMIT: read_mux = position_limit_reg;
			quad_enc_pkg::OFF_RELOAD: read_mux = velocity_period_reload_reg;
			quad_enc_pkg::OFF_TIMER: read_mux = timer_reg;
			quad_enc_pkg::OFF_TALLY: read_mux = running_edge_tally_reg;
			quad_enc_pkg::OFF_TOTAL: read_mux = period_edge_total_reg;
			quad_enc_pkg::OFF_IRQ_EN: read_mux = {28'h000_0000, irq_enable_reg};
			quad_enc_pkg::OFF_IRQ_RAW: read_mux = {28'h000_0000, irq_raw_reg};
			quad_enc_pkg::OFF_IRQ_CLR: read_mux = {28'h000_0000, irq_raw_reg & irq_enable_reg};
			default: read_mux = quad_enc_pkg::RST_WORD;
		endcase
	end

	// single-wait-state slave: ack one cycle after the request, then dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= quad_enc_pkg::RST_WORD;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
				wb_dat_o <= read_mux;
			end
		end
	end

	// checks on the decoded behaviour
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_request;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_answer;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	property p_bus_answer;
		s_request |=> s_answer;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle after request");
	property p_vel_needs_enable;
		encoder_control_reg[quad_enc_pkg::CTL_VEL] |-> encoder_control_reg[quad_enc_pkg::CTL_ENABLE];
	endproperty
	a_vel_needs_enable: assert property (p_vel_needs_enable) else $error("velocity on without enable");
	property p_wrap_up;
		step && up && !wr_pos && !index_hit && position_reg == position_limit_reg |=> position_reg == 32'h0000_0000;
	endproperty
	a_wrap_up: assert property (p_wrap_up) else $error("no wrap to zero at maximum");
	property p_wrap_down;
		step && !up && !wr_pos && !index_hit && position_reg == 32'h0000_0000 |=> position_reg == $past(position_limit_reg);
	endproperty
	a_wrap_down: assert property (p_wrap_down) else $error("no wrap to maximum below zero");
	property p_index_clear;
		index_hit && encoder_control_reg[quad_enc_pkg::CTL_WRAP] && !wr_pos |=> position_reg == 32'h0000_0000;
	endproperty
	a_index_clear: assert property (p_index_clear) else $error("index did not clear position");
	property p_frozen;
		!en && !wr_pos ##1 !en |-> $stable(position_reg) && $stable(running_edge_tally_reg) && $stable(timer_reg);
	endproperty
	a_frozen: assert property (p_frozen) else $error("counting while disabled");
	property p_reload;
		expire && !wr_ctl |=> timer_reg == $past(velocity_period_reload_reg) && running_edge_tally_reg == 32'h0000_0000;
	endproperty
	a_reload: assert property (p_reload) else $error("timer not reloaded at expiry");
	property p_capture;
		expire |=> period_edge_total_reg == $past(tally_sum);
	endproperty
	a_capture: assert property (p_capture) else $error("period total not captured");
	property p_error_raw;
		phase_err |=> irq_raw_reg[quad_enc_pkg::EV_ERR] && err_status;
	endproperty
	a_error_raw: assert property (p_error_raw) else $error("phase error not flagged");
	property p_irq_mask;
		##1 irq_o == |($past(irq_raw_reg) & $past(irq_enable_reg));
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("request does not follow masked status");
	property p_dir_status;
		step |=> dir_status == !$past(up);
	endproperty
	a_dir_status: assert property (p_dir_status) else $error("direction status wrong");
endmodule // quadrature_position_velocity

// file: hw/quad_enc_pkg.sv
// constants shared by the quadrature position and velocity block
package quad_enc_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_POS = 8'h08;
	localparam logic [7:0] OFF_LIMIT = 8'h0C;
	localparam logic [7:0] OFF_RELOAD = 8'h10;
	localparam logic [7:0] OFF_TIMER = 8'h14;
	localparam logic [7:0] OFF_TALLY = 8'h18;
	localparam logic [7:0] OFF_TOTAL = 8'h1C;
	localparam logic [7:0] OFF_IRQ_EN = 8'h20;
	localparam logic [7:0] OFF_IRQ_RAW = 8'h24;
	localparam logic [7:0] OFF_IRQ_CLR = 8'h28;
	// control field positions
	localparam int CTL_ENABLE = 0;
	localparam int CTL_SWAP = 1;
	localparam int CTL_SIG = 2;
	localparam int CTL_EDGE = 3;
	localparam int CTL_WRAP = 4;
	localparam int CTL_VEL = 5;
	localparam int CTL_DIV_LO = 6;
	localparam int CTL_DIV_W = 3;
	// status field positions
	localparam int STAT_ERR = 0;
	localparam int STAT_DIR = 1;
	// event bit positions
	localparam int EV_INDEX = 0;
	localparam int EV_TIMER = 1;
	localparam int EV_DIR = 2;
	localparam int EV_ERR = 3;
	localparam int EV_W = 4;
	// values after reset
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [3:0] RST_EV = 4'h0;
	localparam logic [1:0] RST_SYNC = 2'h0;
	// two flip-flops on every pin input
	localparam int SYNC_STAGES = 2;
endpackage

// file: dv/encoder_model.sv
// encoder partner: quadrature phases, step pulses and index
`timescale 1ns/100ps
module encoder_model (
	input wire logic clk_i,
	output logic a_o,
	output logic b_o,
	output logic idx_o
);
	logic [1:0] p = 2'h0;
	// pins idle low until the bench moves the shaft
	initial begin
		a_o = 1'b0;
		b_o = 1'b0;
		idx_o = 1'b0;
	end
	// states held hold cycles
	// gray order 00,10,11,01 means A leads going forward
	task automatic move(input int n, input bit rev, input int hold);
		repeat (n) begin
			p = rev ? p - 2'h1 : p + 2'h1;
			a_o <= p[0] ^ p[1];
			b_o <= p[1];
			repeat (hold) @(posedge clk_i);
		end
		repeat (2) @(posedge clk_i); // let the sync pipeline drain
	endtask
	// both lines flip together, a broken gray step
	task automatic glitch();
		p = p + 2'h2;
		a_o <= ~a_o;
		b_o <= ~b_o;
		repeat (6) @(posedge clk_i);
	endtask
	// index pulse of four cycles
	task automatic index_pulse();
		idx_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		idx_o <= 1'b0;
		repeat (6) @(posedge clk_i);
	endtask
	// step clock on a, direction level on b
	task automatic step(input bit rev);
		a_o <= 1'b0;
		b_o <= rev;
		repeat (4) @(posedge clk_i);
		a_o <= 1'b1;
		repeat (6) @(posedge clk_i);
	endtask
endmodule // encoder_model

// file: dv/test_quadrature_position_velocity.sv
// self-checking bench for the quadrature position and velocity block
`timescale 1ns/100ps
module test_quadrature_position_velocity;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [3:0] sel = 4'hF;
	logic [31:0] rdat;
	logic ack;
	logic irq;
	logic ch_a;
	logic ch_b;
	logic idx;
	logic [31:0] exp_q[$];
	int err_count = 0;
	int checks_done = 0;
	int r;
	always #2 clk_i = ~clk_i;
	quadrature_position_velocity quadrature_position_velocity_inst (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .encoder_channel_a_i(ch_a),
		.encoder_channel_b_i(ch_b), .index_i(idx), .irq_o(irq));
	encoder_model encoder_model_inst (.clk_i(clk_i), .a_o(ch_a), .b_o(ch_b), .idx_o(idx));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", what, want, seen);
		end
	endtask
	task automatic print_verdict();
		check("pending reads", 32'(exp_q.size()), 32'h0);
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// classic cycle: hold request until ack, then idle one cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 64);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
		if (n >= 64) begin
			err_count++;
			print_verdict();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		wb(1'b0, a, 32'h0);
	endtask
	// scoreboard: oldest noted value against each read answer
	always @(posedge clk_i) begin
		if (ack === 1'b1 && we === 1'b0) begin
			if (exp_q.size() == 0) begin
				check("stray read", 32'h1, 32'h0);
			end else begin
				check($sformatf("reg %h", adr), rdat, exp_q.pop_front());
			end
		end
	end
	initial begin
		r = $urandom(96);
		r = $urandom % 8;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// every place reads zero after reset, the unmapped one too
		for (int i = 0; i < 12; i++) begin
			rd(8'(i * 4), 32'h0);
		end
		// byte lanes: only lanes 0 and 2 are written
		sel <= 4'h5;
		wb(1'b1, quad_enc_pkg::OFF_RELOAD, 32'hAABB_CCDD);
		sel <= 4'hF;
		rd(quad_enc_pkg::OFF_RELOAD, 32'h00BB_00DD);
		wb(1'b1, quad_enc_pkg::OFF_LIMIT, 32'h7); // edges minus one
		wb(1'b1, quad_enc_pkg::OFF_IRQ_EN, 32'hF);
		wb(1'b1, quad_enc_pkg::OFF_CTL, 32'h9);
		encoder_model_inst.move(9, 1'b0, 4);
		rd(quad_enc_pkg::OFF_POS, 32'h1); // up and wrap
		rd(quad_enc_pkg::OFF_STAT, 32'h0); // forward
		encoder_model_inst.move(3, 1'b1, 8);
		rd(quad_enc_pkg::OFF_POS, 32'h6); // below zero
		rd(quad_enc_pkg::OFF_STAT, 32'h2); // reverse
		rd(quad_enc_pkg::OFF_IRQ_RAW, 32'h4); // turn event
		check("irq", {31'h0, irq}, 32'h1); // mask passes
		wb(1'b1, quad_enc_pkg::OFF_IRQ_CLR, 32'h4);
		rd(quad_enc_pkg::OFF_IRQ_RAW, 32'h0); // cleared
		check("irq", {31'h0, irq}, 32'h0); // low again
		// a edges only: two counts per line
		wb(1'b1, quad_enc_pkg::OFF_CTL, 32'h1);
		wb(1'b1, quad_enc_pkg::OFF_POS, 32'h0);
		encoder_model_inst.move(8, 1'b0, 4);
		rd(quad_enc_pkg::OFF_POS, 32'h4); // a edges
		// swap while both lines equal, so no false edge
		wb(1'b1, quad_enc_pkg::OFF_CTL, 32'hB);
		encoder_model_inst.move(4, 1'b0, 4);
		rd(quad_enc_pkg::OFF_POS, 32'h0); // swap reverses
		wb(1'b1, quad_enc_pkg::OFF_CTL, 32'h9);
		wb(1'b1, quad_enc_pkg::OFF_POS, 32'(r));
		encoder_model_inst.index_pulse();
		rd(quad_enc_pkg::OFF_POS, 32'(r)); // index ignored
		wb(1'b1, quad_enc_pkg::OFF_CTL, 32'h19);
		wb(1'b1, quad_enc_pkg::OFF_IRQ_CLR, 32'hF);
		encoder_model_inst.index_pulse();
		rd(quad_enc_pkg::OFF_POS, 32'h0); // index clears
		encoder_model_inst.glitch();
		rd(quad_enc_pkg::OFF_STAT, 32'h3); // phase error
		rd(quad_enc_pkg::OFF_IRQ_RAW, 32'h9); // index and error
		encoder_model_inst.move(1, 1'b0, 4);
		rd(quad_enc_pkg::OFF_STAT, 32'h0); // error cleared by count
		// velocity may not start without the integrator
		wb(1'b1, quad_enc_pkg::OFF_CTL, 32'h20);
		rd(quad_enc_pkg::OFF_CTL, 32'h0); // refused
		wb(1'b1, quad_enc_pkg::OFF_RELOAD, 32'd199); // 200 cycles
		wb(1'b1, quad_enc_pkg::OFF_IRQ_CLR, 32'hF);
		wb(1'b1, quad_enc_pkg::OFF_CTL, 32'h29);
		encoder_model_inst.move(8, 1'b0, 4);
		repeat (180) @(posedge clk_i);
		rd(quad_enc_pkg::OFF_TOTAL, 32'h8); // period total
		rd(quad_enc_pkg::OFF_TALLY, 32'h0); // tally cleared
		rd(quad_enc_pkg::OFF_IRQ_RAW, 32'h2); // expiry event
		rd(quad_enc_pkg::OFF_IRQ_CLR, 32'h2); // masked view
		rd(quad_enc_pkg::OFF_POS, 32'h1); // eight counts wrap
		// divide by two: an expiry first loads the long period, then half the edges reach the tally
		wb(1'b1, quad_enc_pkg::OFF_RELOAD, 32'h0000_FFFF);
		repeat (210) @(posedge clk_i);
		wb(1'b1, quad_enc_pkg::OFF_CTL, 32'h69);
		encoder_model_inst.move(8, 1'b0, 4);
		rd(quad_enc_pkg::OFF_TALLY, 32'h4); // prescaled tally
		rd(quad_enc_pkg::OFF_POS, 32'h1); // position not divided
		// disabled: pins move, nothing counts
		wb(1'b1, quad_enc_pkg::OFF_CTL, 32'h0);
		encoder_model_inst.move(4, 1'b0, 4);
		rd(quad_enc_pkg::OFF_POS, 32'h1); // frozen
		rd(quad_enc_pkg::OFF_TOTAL, 32'h0); // total holds
		rd(quad_enc_pkg::OFF_TALLY, 32'h4); // tally holds
		// step and direction mode
		wb(1'b1, quad_enc_pkg::OFF_CTL, 32'h5);
		wb(1'b1, quad_enc_pkg::OFF_POS, 32'h3);
		repeat (3) encoder_model_inst.step(1'b0);
		repeat (2) encoder_model_inst.step(1'b1);
		rd(quad_enc_pkg::OFF_POS, 32'h4); // steps
		rd(quad_enc_pkg::OFF_STAT, 32'h2); // reverse
		print_verdict();
	end
endmodule // test_quadrature_position_velocity
